// ==== core/cfp_core_regs.sv ====
// Purpose: CPU core register set with condition flags and stack sequencer
// Assumes: Instruction decoder drives op ports; stack RAM answers stk_re in the same cycle
// Notes:   Functional notes
// Functional notes
// - Eight-bit accumulator holds operands and results
// - Two eight-bit index registers for address/data
// - Interrupt entry and return leave Y untouched
// - Sixteen-bit PC kept as separate low/high bytes
// - Core registers have no data memory address
// - Condition register resets to pattern 111x1xxx
// - Flags individually set/tested; whole register pushed/popped
// - Half carry set by carry from bit three
// - Branches test half carry set or clear
// - Negative flag copies result bit seven
// - Zero flag set when result is zero
// - Carry records overflow; set/reset carry instructions force it
// - Bit test, shifts, rotates update carry; tested both ways
// - Priority bits encode software level zero to three
// - Interrupt entry loads priority from source registers
// - Enable, disable, return, halt, wait, pop write priority
// - Interrupt pushes five bytes low PC first; call two
// - Stack pointer resets 01ff, decrement after push, increment before pop
`timescale 1ns/1ps
`default_nettype none
module cfp_core_regs (
  input  wire logic                clk,            // 100 MHz core clock
  input  wire logic                rstn,           // Asynchronous reset, active low
  input  wire logic                op_valid,       // Instruction presented
  input  wire cfp_pkg::cfp_op_e    op,             // Instruction class
  input  wire cfp_pkg::cfp_alu_e   alu_func,       // ALU function
  input  wire cfp_pkg::cfp_dst_e   dst_sel,        // ALU destination
  input  wire cfp_pkg::cfp_cond_e  cond_sel,       // Branch condition
  input  wire logic [2:0]          bit_sel,        // Bit index for bit test
  input  wire logic [7:0]          operand,        // Data operand
  input  wire logic [7:0]          rel_offset,     // Signed branch offset
  input  wire logic [2:0]          op_len,         // Instruction length in bytes
  input  wire logic [15:0]         target,         // Jump, call or vector address
  input  wire logic [1:0]          irq_level,      // Source priority register bits
  input  wire logic [7:0]          stk_rdata,      // Stack read data
  output logic                     op_ready,       // Ready for an instruction
  output logic [7:0]               acc,            // Accumulator
  output logic [7:0]               idx_x,          // First index register
  output logic [7:0]               idx_y,          // Second index register
  output logic [7:0]               pc_low_byte,    // Program counter low byte
  output logic [7:0]               pc_high_byte,   // Program counter high byte
  output logic [15:0]              stack_ptr,      // Stack pointer
  output logic [7:0]               condition_flags_and_priority, // Condition register
  output logic                     branch_taken,   // Pulse: branch was taken
  output logic                     stk_we,         // Stack write strobe
  output logic                     stk_re,         // Stack read strobe
  output logic [15:0]              stk_addr,       // Stack address
  output logic [7:0]               stk_wdata       // Stack write data
);

  // Architectural registers
  logic [7:0]            acc_reg, acc_next;   // Accumulator
  logic [7:0]            x_reg, x_next;       // Index X
  logic [7:0]            y_reg, y_next;       // Index Y
  logic [7:0]            pcl_reg, pch_reg;    // PC bytes
  logic [15:0]           pc_next;             // Next PC as one word
  logic [5:0]            cc_reg, cc_next;     // Low six condition bits
  logic [7:0]            sp_reg, sp_next;     // Stack pointer low byte
  // Sequencer registers
  cfp_pkg::cfp_state_e   st_reg, st_next;
  cfp_pkg::cfp_kind_e    kind_reg, kind_next;
  logic [2:0]            step_reg, step_next;
  logic [15:0]           tgt_reg, tgt_next;   // Address loaded at frame end
  logic [1:0]            lvl_reg, lvl_next;   // Level loaded at interrupt end
  logic                  rdy_reg, rdy_next;
  logic                  br_reg, br_next;
  logic                  we_reg, we_next;
  logic                  re_reg, re_next;
  logic [15:0]           addr_reg, addr_next;
  logic [7:0]            wd_reg, wd_next;

  // Frame length of a kind
  function automatic logic [2:0] frame_len(input cfp_pkg::cfp_kind_e k);
    unique case (k)
      cfp_pkg::CFP_K_INTR: frame_len = cfp_pkg::CFP_N_INTR;
      cfp_pkg::CFP_K_CALL: frame_len = cfp_pkg::CFP_N_CALL;
      default:             frame_len = cfp_pkg::CFP_N_CC;
    endcase
  endfunction : frame_len

  // Byte in slot i of a frame, slot 0 nearest the old stack top
  function automatic cfp_pkg::cfp_sel_e slot_sel(input cfp_pkg::cfp_kind_e k,
                                                 input logic [2:0] i);
    if (k == cfp_pkg::CFP_K_CC) begin
      slot_sel = cfp_pkg::CFP_SEL_CC;
    end else begin
      unique case (i)
        3'h0:    slot_sel = cfp_pkg::CFP_SEL_PCL;   // Low PC first
        3'h1:    slot_sel = cfp_pkg::CFP_SEL_PCH;
        3'h2:    slot_sel = cfp_pkg::CFP_SEL_X;
        3'h3:    slot_sel = cfp_pkg::CFP_SEL_A;
        default: slot_sel = cfp_pkg::CFP_SEL_CC;
      endcase
    end
  endfunction : slot_sel

  // Branch condition against a condition byte
  function automatic logic cond_true(input cfp_pkg::cfp_cond_e cd,
                                     input logic [5:0] f);
    unique case (cd)
      cfp_pkg::CFP_CND_H:  cond_true = f[cfp_pkg::CFP_BIT_H];
      cfp_pkg::CFP_CND_NH: cond_true = !f[cfp_pkg::CFP_BIT_H];
      cfp_pkg::CFP_CND_MI: cond_true = f[cfp_pkg::CFP_BIT_N];
      cfp_pkg::CFP_CND_PL: cond_true = !f[cfp_pkg::CFP_BIT_N];
      cfp_pkg::CFP_CND_EQ: cond_true = f[cfp_pkg::CFP_BIT_Z];
      cfp_pkg::CFP_CND_NE: cond_true = !f[cfp_pkg::CFP_BIT_Z];
      cfp_pkg::CFP_CND_C:  cond_true = f[cfp_pkg::CFP_BIT_C];
      cfp_pkg::CFP_CND_NC: cond_true = !f[cfp_pkg::CFP_BIT_C];
      default:             cond_true = 1'b1;
    endcase
  endfunction : cond_true

  // Register file reached only through the op port, no address
  wire logic        accept   = op_valid && rdy_reg;
  wire logic [15:0] pc_cur   = {pch_reg, pcl_reg};
  wire logic [15:0] pc_seq   = pc_cur + {13'h0000, op_len};
  wire logic [15:0] pc_rel   = pc_seq + {{8{rel_offset[7]}}, rel_offset};
  wire logic [7:0]  cc_full  = {cfp_pkg::CFP_CC_TOP, cc_reg};
  wire logic        last     = (step_reg == frame_len(kind_reg) - 3'h1);
  wire logic        is_pop   = (st_reg == cfp_pkg::CFP_ST_TAKE);

  // Slot index; pops walk the frame backwards
  wire logic [2:0]  slot_idx = is_pop ? (frame_len(kind_reg) - 3'h1 - step_reg)
                                      : step_reg;
  wire cfp_pkg::cfp_sel_e sel = slot_sel(kind_reg, slot_idx);

  // Push data mux; Y has no slot at all
  wire logic [7:0] push_byte = (sel == cfp_pkg::CFP_SEL_PCL) ? pcl_reg :
                               (sel == cfp_pkg::CFP_SEL_PCH) ? pch_reg :
                               (sel == cfp_pkg::CFP_SEL_X)   ? x_reg   :
                               (sel == cfp_pkg::CFP_SEL_A)   ? acc_reg : cc_full;

  // ALU operand selection
  wire logic [7:0] alu_a = (dst_sel == cfp_pkg::CFP_DST_X) ? x_reg :
                           (dst_sel == cfp_pkg::CFP_DST_Y) ? y_reg : acc_reg;
  logic [7:0] alu_res;
  logic       alu_h;
  logic       alu_c;
  logic       alu_h_upd;
  logic       alu_c_upd;

  // Bit test result, fed into the carry before the condition check
  wire logic       bit_val = operand[bit_sel];
  wire logic [5:0] cc_btj  = {cc_reg[5:1], bit_val};

  cfp_alu u_alu (
    .func  (alu_func),
    .a     (alu_a),
    .b     (operand),
    .cin   (cc_reg[cfp_pkg::CFP_BIT_C]),
    .res   (alu_res),
    .h     (alu_h),
    .c     (alu_c),
    .h_upd (alu_h_upd),
    .c_upd (alu_c_upd)
  );

  // Next-state logic for registers and the stack sequencer
  always_comb begin
    acc_next  = acc_reg;
    x_next    = x_reg;
    y_next    = y_reg;
    pc_next   = pc_cur;
    cc_next   = cc_reg;
    sp_next   = sp_reg;
    st_next   = st_reg;
    kind_next = kind_reg;
    step_next = step_reg;
    tgt_next  = tgt_reg;
    lvl_next  = lvl_reg;
    rdy_next  = rdy_reg;
    br_next   = 1'b0;
    we_next   = 1'b0;
    re_next   = 1'b0;
    addr_next = addr_reg;
    wd_next   = wd_reg;
    unique case (st_reg)
      cfp_pkg::CFP_ST_IDLE: begin
        if (accept) begin
          pc_next = pc_seq;
          unique case (op)
            cfp_pkg::CFP_OP_ALU: begin
              // Result and flags land on the same edge
              unique case (dst_sel)
                cfp_pkg::CFP_DST_X: x_next = alu_res;
                cfp_pkg::CFP_DST_Y: y_next = alu_res;
                default:            acc_next = alu_res;
              endcase
              cc_next[cfp_pkg::CFP_BIT_N] = alu_res[cfp_pkg::CFP_MSB];
              cc_next[cfp_pkg::CFP_BIT_Z] = (alu_res == 8'h00);
              if (alu_h_upd) cc_next[cfp_pkg::CFP_BIT_H] = alu_h;
              if (alu_c_upd) cc_next[cfp_pkg::CFP_BIT_C] = alu_c;
            end
            cfp_pkg::CFP_OP_SCF: cc_next[cfp_pkg::CFP_BIT_C] = 1'b1;
            cfp_pkg::CFP_OP_RCF: cc_next[cfp_pkg::CFP_BIT_C] = 1'b0;
            // Priority written by instructions
            cfp_pkg::CFP_OP_RIM,
            cfp_pkg::CFP_OP_HALT,
            cfp_pkg::CFP_OP_WFE: begin
              {cc_next[cfp_pkg::CFP_BIT_I1], cc_next[cfp_pkg::CFP_BIT_I0]} =
                cfp_pkg::CFP_LVL_MAIN;
            end
            cfp_pkg::CFP_OP_SIM: begin
              {cc_next[cfp_pkg::CFP_BIT_I1], cc_next[cfp_pkg::CFP_BIT_I0]} =
                cfp_pkg::CFP_LVL_DIS;
            end
            cfp_pkg::CFP_OP_BRANCH: begin
              br_next = cond_true(cond_sel, cc_reg);
              pc_next = br_next ? pc_rel : pc_seq;
            end
            cfp_pkg::CFP_OP_BTJ: begin
              cc_next = cc_btj;
              br_next = cond_true(cond_sel, cc_btj);
              pc_next = br_next ? pc_rel : pc_seq;
            end
            cfp_pkg::CFP_OP_JP: pc_next = target;
            cfp_pkg::CFP_OP_RSP: sp_next = cfp_pkg::CFP_SP_LO_RST;
            cfp_pkg::CFP_OP_CALL,
            cfp_pkg::CFP_OP_INTR,
            cfp_pkg::CFP_OP_PUSHCC: begin
              // Interrupt saves the current PC, call the following one
              if (op == cfp_pkg::CFP_OP_INTR) pc_next = pc_cur;
              kind_next = (op == cfp_pkg::CFP_OP_INTR) ? cfp_pkg::CFP_K_INTR :
                          (op == cfp_pkg::CFP_OP_CALL) ? cfp_pkg::CFP_K_CALL :
                                                          cfp_pkg::CFP_K_CC;
              tgt_next  = target;
              lvl_next  = irq_level;
              step_next = 3'h0;
              rdy_next  = 1'b0;
              st_next   = cfp_pkg::CFP_ST_PUSH;
            end
            cfp_pkg::CFP_OP_RET,
            cfp_pkg::CFP_OP_INTERRUPT_RETURN_INSTR,
            cfp_pkg::CFP_OP_POPCC: begin
              kind_next = (op == cfp_pkg::CFP_OP_INTERRUPT_RETURN_INSTR) ? cfp_pkg::CFP_K_INTR :
                          (op == cfp_pkg::CFP_OP_RET)  ? cfp_pkg::CFP_K_CALL :
                                                          cfp_pkg::CFP_K_CC;
              step_next = 3'h0;
              rdy_next  = 1'b0;
              st_next   = cfp_pkg::CFP_ST_ISSUE;
            end
            cfp_pkg::CFP_OP_NOP: pc_next = pc_seq;
            default: pc_next = pc_cur;   // Illegal code is ignored
          endcase
        end
      end
      cfp_pkg::CFP_ST_PUSH: begin
        // Write at pointer, then decrement
        we_next   = 1'b1;
        addr_next = {cfp_pkg::CFP_SP_HI, sp_reg};
        wd_next   = push_byte;
        sp_next   = sp_reg - 8'h01;
        step_next = step_reg + 3'h1;
        if (last) begin
          st_next  = cfp_pkg::CFP_ST_IDLE;
          rdy_next = 1'b1;
          if (kind_reg != cfp_pkg::CFP_K_CC) pc_next = tgt_reg;
          if (kind_reg == cfp_pkg::CFP_K_INTR) begin
            // Level from the source priority registers
            {cc_next[cfp_pkg::CFP_BIT_I1], cc_next[cfp_pkg::CFP_BIT_I0]} = lvl_reg;
          end
        end
      end
      cfp_pkg::CFP_ST_ISSUE: begin
        // Increment before the read
        sp_next   = sp_reg + 8'h01;
        re_next   = 1'b1;
        addr_next = {cfp_pkg::CFP_SP_HI, sp_reg + 8'h01};
        st_next   = cfp_pkg::CFP_ST_TAKE;
      end
      cfp_pkg::CFP_ST_TAKE: begin
        // Restore one byte; Y is never a target
        unique case (sel)
          cfp_pkg::CFP_SEL_PCL: pc_next[7:0]  = stk_rdata;
          cfp_pkg::CFP_SEL_PCH: pc_next[15:8] = stk_rdata;
          cfp_pkg::CFP_SEL_X:   x_next = stk_rdata;
          cfp_pkg::CFP_SEL_A:   acc_next = stk_rdata;
          default:              cc_next = stk_rdata[5:0];
        endcase
        step_next = step_reg + 3'h1;
        if (last) begin
          st_next  = cfp_pkg::CFP_ST_IDLE;
          rdy_next = 1'b1;
        end else begin
          st_next  = cfp_pkg::CFP_ST_ISSUE;
        end
      end
    endcase
  end

  // Architectural state; values at reset
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      acc_reg <= cfp_pkg::CFP_DATA_RST;
      x_reg   <= cfp_pkg::CFP_DATA_RST;
      y_reg   <= cfp_pkg::CFP_DATA_RST;
      pcl_reg <= cfp_pkg::CFP_PC_RST[7:0];
      pch_reg <= cfp_pkg::CFP_PC_RST[15:8];
      cc_reg  <= cfp_pkg::CFP_CC_RST;
      sp_reg  <= cfp_pkg::CFP_SP_LO_RST;
    end else begin
      acc_reg <= acc_next;
      x_reg   <= x_next;
      y_reg   <= y_next;
      pcl_reg <= pc_next[7:0];
      pch_reg <= pc_next[15:8];
      cc_reg  <= cc_next;
      sp_reg  <= sp_next;
    end
  end

  // Sequencer and strobe state
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_reg   <= cfp_pkg::CFP_ST_IDLE;
      kind_reg <= cfp_pkg::CFP_K_CC;
      step_reg <= 3'h0;
      tgt_reg  <= cfp_pkg::CFP_PC_RST;
      lvl_reg  <= cfp_pkg::CFP_LVL_DIS;
      rdy_reg  <= 1'b1;
      br_reg   <= 1'b0;
      we_reg   <= 1'b0;
      re_reg   <= 1'b0;
      addr_reg <= {cfp_pkg::CFP_SP_HI, cfp_pkg::CFP_SP_LO_RST};
      wd_reg   <= cfp_pkg::CFP_DATA_RST;
    end else begin
      st_reg   <= st_next;
      kind_reg <= kind_next;
      step_reg <= step_next;
      tgt_reg  <= tgt_next;
      lvl_reg  <= lvl_next;
      rdy_reg  <= rdy_next;
      br_reg   <= br_next;
      we_reg   <= we_next;
      re_reg   <= re_next;
      addr_reg <= addr_next;
      wd_reg   <= wd_next;
    end
  end

  // Outputs straight from flip-flops; fixed bits are constants
  assign op_ready     = rdy_reg;
  assign acc          = acc_reg;
  assign idx_x        = x_reg;
  assign idx_y        = y_reg;
  assign pc_low_byte  = pcl_reg;
  assign pc_high_byte = pch_reg;
  assign stack_ptr    = {cfp_pkg::CFP_SP_HI, sp_reg};
  assign condition_flags_and_priority = cc_full;
  assign branch_taken = br_reg;
  assign stk_we       = we_reg;
  assign stk_re       = re_reg;
  assign stk_addr     = addr_reg;
  assign stk_wdata    = wd_reg;

endmodule : cfp_core_regs
`default_nettype wire

// ==== core/cfp_pkg.sv ====
// Purpose: Shared constants and types for the CPU core register and flag block
// Assumes: One 100 MHz clock, asynchronous active-low reset
// Notes:   Stack memory lives outside; this block only drives its strobes
package cfp_pkg;

  // Condition register bit positions
  localparam int unsigned CFP_BIT_C  = 0;
  localparam int unsigned CFP_BIT_Z  = 1;
  localparam int unsigned CFP_BIT_N  = 2;
  localparam int unsigned CFP_BIT_I0 = 3;
  localparam int unsigned CFP_BIT_H  = 4;
  localparam int unsigned CFP_BIT_I1 = 5;
  localparam int unsigned CFP_MSB    = 7;

  // Reset values; undefined condition bits are taken as zero
  localparam logic [1:0]  CFP_CC_TOP    = 2'h3;   // Bits 7:6 always read one
  localparam logic [5:0]  CFP_CC_RST    = 6'h28;  // Low six bits of 8'he8
  localparam logic [7:0]  CFP_DATA_RST  = 8'h00;
  localparam logic [15:0] CFP_PC_RST    = 16'h0000;
  localparam logic [7:0]  CFP_SP_HI     = 8'h01;  // Upper stack byte fixed
  localparam logic [7:0]  CFP_SP_LO_RST = 8'hff;

  // Priority levels as {high bit, low bit}
  localparam logic [1:0] CFP_LVL_MAIN = 2'h2;
  localparam logic [1:0] CFP_LVL_ONE  = 2'h1;
  localparam logic [1:0] CFP_LVL_TWO  = 2'h0;
  localparam logic [1:0] CFP_LVL_DIS  = 2'h3;

  // Stack frame lengths
  localparam logic [2:0] CFP_N_INTR = 3'h5;
  localparam logic [2:0] CFP_N_CALL = 3'h2;
  localparam logic [2:0] CFP_N_CC   = 3'h1;

  // Instruction classes presented by the instruction decoder
  typedef enum logic [4:0] {
    CFP_OP_NOP    = 5'h00,
    CFP_OP_ALU    = 5'h01,
    CFP_OP_SCF    = 5'h02,
    CFP_OP_RCF    = 5'h03,
    CFP_OP_RIM    = 5'h04,
    CFP_OP_SIM    = 5'h05,
    CFP_OP_HALT   = 5'h06,
    CFP_OP_WFE    = 5'h07,
    CFP_OP_BRANCH = 5'h08,
    CFP_OP_BTJ    = 5'h09,
    CFP_OP_JP     = 5'h0a,
    CFP_OP_CALL   = 5'h0b,
    CFP_OP_RET    = 5'h0c,
    CFP_OP_INTERRUPT_RETURN_INSTR   = 5'h0d,
    CFP_OP_INTR   = 5'h0e,
    CFP_OP_PUSHCC = 5'h0f,
    CFP_OP_POPCC  = 5'h10,
    CFP_OP_RSP    = 5'h11
  } cfp_op_e;

  // ALU functions
  typedef enum logic [3:0] {
    CFP_ALU_LD  = 4'h0,
    CFP_ALU_ADD = 4'h1,
    CFP_ALU_ADC = 4'h2,
    CFP_ALU_SUB = 4'h3,
    CFP_ALU_AND = 4'h4,
    CFP_ALU_OR  = 4'h5,
    CFP_ALU_XOR = 4'h6,
    CFP_ALU_SLL = 4'h7,
    CFP_ALU_SRL = 4'h8,
    CFP_ALU_RLC = 4'h9
  } cfp_alu_e;

  // Branch conditions
  typedef enum logic [3:0] {
    CFP_CND_ALWAYS = 4'h0,
    CFP_CND_H      = 4'h1,
    CFP_CND_NH     = 4'h2,
    CFP_CND_MI     = 4'h3,
    CFP_CND_PL     = 4'h4,
    CFP_CND_EQ     = 4'h5,
    CFP_CND_NE     = 4'h6,
    CFP_CND_C      = 4'h7,
    CFP_CND_NC     = 4'h8
  } cfp_cond_e;

  // Destination of an ALU result
  typedef enum logic [1:0] {
    CFP_DST_A = 2'h0,
    CFP_DST_X = 2'h1,
    CFP_DST_Y = 2'h2
  } cfp_dst_e;

  // Stack sequencer states
  typedef enum logic [1:0] {
    CFP_ST_IDLE  = 2'h0,
    CFP_ST_PUSH  = 2'h1,
    CFP_ST_ISSUE = 2'h2,
    CFP_ST_TAKE  = 2'h3
  } cfp_state_e;

  // Stack frame kinds
  typedef enum logic [1:0] {
    CFP_K_INTR = 2'h0,
    CFP_K_CALL = 2'h1,
    CFP_K_CC   = 2'h2
  } cfp_kind_e;

  // Byte carried by one stack slot
  typedef enum logic [2:0] {
    CFP_SEL_PCL = 3'h0,
    CFP_SEL_PCH = 3'h1,
    CFP_SEL_X   = 3'h2,
    CFP_SEL_A   = 3'h3,
    CFP_SEL_CC  = 3'h4
  } cfp_sel_e;

endpackage : cfp_pkg

// ==== core/cfp_alu.sv ====
// Purpose: Combinational ALU producing result and carry-type flags
// Assumes: Caller derives sign and zero flags from the result
// Notes:   Half carry only meaningful for add forms
`timescale 1ns/1ps
`default_nettype none
module cfp_alu (
  input  wire cfp_pkg::cfp_alu_e func,     // Operation
  input  wire logic [7:0]        a,        // Left operand
  input  wire logic [7:0]        b,        // Right operand
  input  wire logic              cin,      // Current carry flag
  output logic [7:0]             res,      // Result
  output logic                   h,        // Half carry
  output logic                   c,        // Carry or borrow
  output logic                   h_upd,    // Half carry is to be written
  output logic                   c_upd     // Carry is to be written
);

  // Carry-in only for add-with-carry
  wire logic       add_cin = (func == cfp_pkg::CFP_ALU_ADC) ? cin : 1'b0;
  wire logic [8:0] sum9    = {1'b0, a} + {1'b0, b} + {8'h00, add_cin};
  wire logic [4:0] nib5    = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, add_cin};
  wire logic [8:0] diff9   = {1'b0, a} - {1'b0, b};

  // Function select; flags not written keep their old value outside
  always_comb begin
    res   = b;
    h     = 1'b0;
    c     = cin;
    h_upd = 1'b0;
    c_upd = 1'b0;
    unique case (func)
      cfp_pkg::CFP_ALU_LD:  res = b;
      cfp_pkg::CFP_ALU_ADD,
      cfp_pkg::CFP_ALU_ADC: begin
        res   = sum9[7:0];
        h     = nib5[4];    // Carry out of bit 3
        c     = sum9[8];
        h_upd = 1'b1;
        c_upd = 1'b1;
      end
      cfp_pkg::CFP_ALU_SUB: begin
        res   = diff9[7:0];
        c     = diff9[8];   // Borrow
        c_upd = 1'b1;
      end
      cfp_pkg::CFP_ALU_AND: res = a & b;
      cfp_pkg::CFP_ALU_OR:  res = a | b;
      cfp_pkg::CFP_ALU_XOR: res = a ^ b;
      cfp_pkg::CFP_ALU_SLL: begin
        res   = {b[6:0], 1'b0};
        c     = b[7];
        c_upd = 1'b1;
      end
      cfp_pkg::CFP_ALU_SRL: begin
        res   = {1'b0, b[7:1]};
        c     = b[0];
        c_upd = 1'b1;
      end
      cfp_pkg::CFP_ALU_RLC: begin
        res   = {b[6:0], cin};
        c     = b[7];
        c_upd = 1'b1;
      end
      default: res = b;     // Unused codes act as a load
    endcase
  end

endmodule : cfp_alu
`default_nettype wire

// ==== testbench/cfp_monitor.sv ====
// Purpose: Port assertions for the core register block
// Assumes: One clock, reset active low
// Notes: Bound to every cfp_core_regs
`timescale 1ns/1ps
`default_nettype none
module cfp_monitor (
  input wire logic             clk,
  input wire logic             rstn,
  input wire logic             op_valid,
  input wire cfp_pkg::cfp_op_e op,
  input wire logic [1:0]       irq_level,
  input wire logic             op_ready,
  input wire logic [7:0]       idx_y,
  input wire logic [7:0]       pc_low_byte,
  input wire logic [15:0]      stack_ptr,
  input wire logic [7:0]       condition_flags_and_priority,
  input wire logic             stk_we,
  input wire logic [15:0]      stk_addr,
  input wire logic [7:0]       stk_wdata
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // Short views of the condition byte and of a taken op
  wire logic [7:0] cc   = condition_flags_and_priority;
  wire logic [1:0] lvl  = {cc[5], cc[3]};
  wire logic       take = op_valid && op_ready;
  wire logic       intr = take && op == cfp_pkg::CFP_OP_INTR;
  a_cc_top_ones: assert property (cc[7:6] == 2'h3)
    else $error("top bits low");
  a_sp_high_fixed: assert property (stack_ptr[15:8] == 8'h01)
    else $error("stack high byte moved");
  a_intr_frame_len: assert property (intr |=> !op_ready [*5] ##1 op_ready)
    else $error("frame length wrong");
  a_intr_low_first: assert property (intr |-> ##2 stk_we && stk_addr == $past(stack_ptr, 2)
    && stk_wdata == $past(pc_low_byte, 2)) else $error("first pushed byte wrong");
  a_intr_prio_load: assert property (intr |-> ##6 lvl == $past(irq_level, 6))
    else $error("level not loaded");
  a_intr_keeps_y: assert property (intr |=> $stable(idx_y) [*6])
    else $error("second index moved");
  a_sim_disables: assert property (take && op == cfp_pkg::CFP_OP_SIM |=> lvl == 2'h3)
    else $error("level not three");
  a_set_carry: assert property (take && op == cfp_pkg::CFP_OP_SCF |=> cc[0])
    else $error("carry not set");
endmodule : cfp_monitor
bind cfp_core_regs cfp_monitor u_mon (.*);
`default_nettype wire

// ==== testbench/cfp_core_regs_tb.sv ====
// Purpose: Self-checking bench for the core register block
// Assumes: Stack RAM lives here, read data follows the strobe address at once
// Notes: Ops spaced by one idle cycle
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
  $display("wrong value at %0t: got %h want %h", $time, g, e); end end
module cfp_core_regs_tb;
  logic clk = 1'b0, rstn = 1'b0, op_valid = 1'b0;
  cfp_pkg::cfp_op_e   op       = cfp_pkg::CFP_OP_NOP;
  cfp_pkg::cfp_alu_e  alu_func = cfp_pkg::CFP_ALU_LD;
  cfp_pkg::cfp_dst_e  dst_sel  = cfp_pkg::CFP_DST_A;
  cfp_pkg::cfp_cond_e cond_sel = cfp_pkg::CFP_CND_ALWAYS;
  logic [2:0]  bit_sel = 3'h0, op_len = 3'h1;
  logic [7:0]  operand = 8'h00, rel_offset = 8'h04;
  logic [15:0] target = 16'h0000, stack_ptr, stk_addr;
  logic [1:0]  irq_level = 2'h0;
  logic op_ready, branch_taken, stk_we, stk_re;
  logic [7:0] acc, idx_x, idx_y, pc_low_byte, pc_high_byte, stk_wdata;
  logic [7:0] condition_flags_and_priority;
  logic [7:0] mem [256];  // Stack RAM; the core takes the byte while stk_re stands
  wire logic [7:0]  stk_rdata = mem[stk_addr[7:0]];
  wire logic [7:0]  cc = condition_flags_and_priority;
  wire logic [15:0] pc = {pc_high_byte, pc_low_byte};
  int error_cnt = 0, tests_run = 0, cyc = 0;
  cfp_core_regs dut (.*);
  always #5 clk = ~clk;
  // RAM write and run ceiling
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (stk_we) mem[stk_addr[7:0]] <= stk_wdata;
    if (cyc == 3000) begin
      error_cnt++;
      wrap_up();
    end
  end
  task automatic idle;
    @(posedge clk);
    #1;
  endtask : idle
  // One op, then wait for the frame to end
  task automatic issue(input cfp_pkg::cfp_op_e o, input cfp_pkg::cfp_alu_e f = cfp_pkg::CFP_ALU_LD,
                       input cfp_pkg::cfp_dst_e d = cfp_pkg::CFP_DST_A, input logic [7:0] v = 8'h00);
    int n;
    idle();
    op = o;
    alu_func = f;
    dst_sel = d;
    operand = v;
    op_valid = 1'b1;
    idle();
    op_valid = 1'b0;
    for (n = 0; n < 40 && op_ready !== 1'b1; n++) idle();
  endtask : issue
  task automatic t_reset;
    `CHK({cc, stack_ptr, acc, pc}, 48'he801ff000000)
  endtask : t_reset
  // Sign, nibble carry, wrap to zero, branches both ways
  task automatic t_alu;
    issue(cfp_pkg::CFP_OP_ALU, cfp_pkg::CFP_ALU_LD, cfp_pkg::CFP_DST_A, 8'h80);
    `CHK(cc[2:1], 2'h2)
    issue(cfp_pkg::CFP_OP_ALU, cfp_pkg::CFP_ALU_LD, cfp_pkg::CFP_DST_X, 8'h0f);
    issue(cfp_pkg::CFP_OP_ALU, cfp_pkg::CFP_ALU_ADD, cfp_pkg::CFP_DST_X, 8'h01);
    `CHK({idx_x, cc[4], cc[1]}, 10'h042)
    cond_sel = cfp_pkg::CFP_CND_H;
    issue(cfp_pkg::CFP_OP_BRANCH);
    `CHK(branch_taken, 1'b1)
    cond_sel = cfp_pkg::CFP_CND_NH;
    issue(cfp_pkg::CFP_OP_BRANCH);
    `CHK(branch_taken, 1'b0)
    issue(cfp_pkg::CFP_OP_ALU, cfp_pkg::CFP_ALU_ADD, cfp_pkg::CFP_DST_A, 8'h80);
    `CHK({acc, cc[4], cc[2:0]}, 12'h003)
  endtask : t_alu
  task automatic t_flags;
    issue(cfp_pkg::CFP_OP_SCF);
    `CHK(cc[0], 1'b1)
    issue(cfp_pkg::CFP_OP_RCF);
    `CHK(cc[0], 1'b0)
    issue(cfp_pkg::CFP_OP_SIM);
    `CHK({cc[5], cc[3]}, 2'h3)
    issue(cfp_pkg::CFP_OP_RIM);
    `CHK({cc[5], cc[3]}, 2'h2)
  endtask : t_flags
  // Interrupt frame out and back; second index must survive
  task automatic t_intr;
    issue(cfp_pkg::CFP_OP_ALU, cfp_pkg::CFP_ALU_LD, cfp_pkg::CFP_DST_Y, 8'h5a);
    issue(cfp_pkg::CFP_OP_ALU, cfp_pkg::CFP_ALU_LD, cfp_pkg::CFP_DST_X, 8'h77);
    issue(cfp_pkg::CFP_OP_ALU, cfp_pkg::CFP_ALU_LD, cfp_pkg::CFP_DST_A, 8'h3c);
    target = 16'h1234;
    issue(cfp_pkg::CFP_OP_JP);
    target = 16'h8000;
    irq_level = 2'h1;
    issue(cfp_pkg::CFP_OP_INTR);
    idle();
    `CHK({pc, cc, stack_ptr}, 40'h8000c801fa)
    `CHK({mem[255], mem[254], mem[253], mem[252], mem[251]}, 40'h3412773ce0)
    issue(cfp_pkg::CFP_OP_INTERRUPT_RETURN_INSTR);
    idle();
    `CHK({pc, cc, stack_ptr, idx_y}, 48'h1234e001ff5a)
  endtask : t_intr
  task automatic wrap_up;
    $display("errors %0d checks %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : wrap_up
  initial begin
    foreach (mem[i]) mem[i] = 8'h00;
    repeat (6) @(posedge clk);
    #1;
    rstn = 1'b1;
    t_reset();
    t_alu();
    t_flags();
    t_intr();
    wrap_up();
  end
endmodule : cfp_core_regs_tb
`default_nettype wire
